// ---- gpio_alternate_function_mux.sv ----
// Behaviour
// - pins with an active-low function are asserted low, deasserted high.
// - the reference clock strap picks 100 MHz when low, 125 MHz when high.
// - a pin without its alternate selected is a plain bidirectional pin.
// - pin 0 as alternate drives the active-low reset of downstream port 2.
// - pin 1 as alternate drives the active-low reset of downstream port 4.
// - pins 2 to 4 as alternate take active-low expander 0 to 2 interrupts.
// - pins 9 and 10 as alternate drive resets of ports 3 and 5.
// - pin 7 as alternate drives the active-low general purpose event.
// - software sets each pin as input or output on its own.
// - alternate select comes from bus writes, serial management or eeprom.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_mux_defs.svh"
module gpio_alternate_function_mux
  import gpio_mux_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // general purpose pins
  input wire logic [10:0] gpio_in_i,
  output logic [10:0] gpio_out_o,
  output logic [10:0] gpio_oe_o,
  // reference clock strap and result for clock generation
  input wire logic refclk_freq_select_i,
  output logic ref_is_125_o,
  output logic [7:0] ref_mhz_o,
  // alternate select loads from serial management and eeprom
  input wire alt_load_t smb_alt_i,
  input wire alt_load_t eeprom_alt_i,
  // internal requests: ports 2,3,4,5 reset and general event, active high
  input wire logic [3:0] port_reset_req_i,
  input wire logic gpe_req_i,
  // expander interrupt levels and block interrupt
  output logic [2:0] expander_irq_o,
  output logic irq_o
);
  logic [10:0] dir;
  logic [10:0] dout;
  logic [10:0] alt_sel;
  logic [`CTRL_W-1:0] ctrl;
  logic [`EVT_W-1:0] status;
  logic [`EVT_W-1:0] enable;
  logic [10:0] pin_lvl;
  logic strap_lvl;
  logic [2:0] settle_cnt;
  logic strap_taken;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic wr_now;
  logic [31:0] next_rdata;
  logic [10:0] alt_assert;
  logic [10:0] next_out;
  logic [10:0] next_oe;
  logic [2:0] exp_active;
  logic [2:0] exp_active_q;
  logic [`EVT_W-1:0] exp_event;
  logic [`CTRL_W-1:0] drive;
  // masks held as constants so one pin's bit can be picked out
  localparam logic [10:0] alt_out_mask = `ALT_OUT_MASK;
  localparam logic [10:0] alt_in_mask = `ALT_IN_MASK;

  // pins and strap come from outside the clock domain
  pin_sync #(
    .W(`GPIO_W),
    .INIT(`PIN_IDLE)
  ) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(gpio_in_i),
    .q_o(pin_lvl)
  );

  pin_sync #(
    .W(1),
    .INIT(1'b0)
  ) u_strap_sync (
    .clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(refclk_freq_select_i),
    .q_o(strap_lvl)
  );

  // bus address phase: every transfer is zero wait, always okay
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;
  assign wr_now = wr_pend;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else begin
      wr_pend <= addr_ok & hwrite_i;
      wr_addr <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // read mux sampled in the address phase; unmapped reads give zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr_i[7:0])
      `OFS_DIR: next_rdata[10:0] = dir;
      `OFS_DOUT: next_rdata[10:0] = dout;
      `OFS_PIN_IN: next_rdata[10:0] = pin_lvl;
      `OFS_ALT_SEL: next_rdata[10:0] = alt_sel;
      `OFS_CTRL: next_rdata[`CTRL_W-1:0] = ctrl;
      `OFS_STATUS: next_rdata[`EVT_W-1:0] = status;
      `OFS_ENABLE: next_rdata[`EVT_W-1:0] = enable;
      `OFS_REFCLK: next_rdata[15:0] = {ref_mhz_o, 7'h00, ref_is_125_o};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_i) begin
      hrdata_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir <= `DIR_RST;
      dout <= `DOUT_RST;
    end else if (wr_now) begin
      if (wr_addr == `OFS_DIR) begin
        dir <= hwdata_i[10:0];
      end
      if (wr_addr == `OFS_DOUT) begin
        dout <= hwdata_i[10:0];
      end
    end
  end

  // three select sources
  // bus write beats serial management, which beats eeprom, in one cycle
  // mask fixed pins
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alt_sel <= `ALT_SEL_RST;
    end else if (wr_now && wr_addr == `OFS_ALT_SEL) begin
      alt_sel <= hwdata_i[10:0] & `ALT_ANY_MASK;
    end else if (smb_alt_i.load) begin
      alt_sel <= smb_alt_i.sel & `ALT_ANY_MASK;
    end else if (eeprom_alt_i.load) begin
      alt_sel <= eeprom_alt_i.sel & `ALT_ANY_MASK;
    end
  end

  // software assert bits for the alternate outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= `CTRL_RST;
    end else if (wr_now && wr_addr == `OFS_CTRL) begin
      ctrl <= hwdata_i[`CTRL_W-1:0];
    end
  end

  // either software or the switch core may assert a reset or event
  assign drive = ctrl | {gpe_req_i, port_reset_req_i};

  // map each alternate output onto its pin position
  always_comb begin
    alt_assert = 11'h000;
    alt_assert[`PIN_PORT2_RST] = drive[`CTRL_PORT2];
    alt_assert[`PIN_PORT4_RST] = drive[`CTRL_PORT4];
    alt_assert[`PIN_GPE] = drive[`CTRL_GPE];
    alt_assert[`PIN_PORT3_RST] = drive[`CTRL_PORT3];
    alt_assert[`PIN_PORT5_RST] = drive[`CTRL_PORT5];
  end

  // per-pin mux; alternate inputs release the pin, outputs drive it
  genvar i;
  generate
    for (i = 0; i < `GPIO_W; i++) begin : g_pin
      always_comb begin
        if (alt_sel[i] && alt_out_mask[i]) begin
          next_oe[i] = 1'b1;
          next_out[i] = ~alt_assert[i];
        end else if (alt_sel[i] && alt_in_mask[i]) begin
          next_oe[i] = 1'b0;
          next_out[i] = 1'b1;
        end else begin
          next_oe[i] = dir[i];
          next_out[i] = dout[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpio_oe_o <= 11'h000;
      gpio_out_o <= `PIN_IDLE;
    end else begin
      gpio_oe_o <= next_oe;
      gpio_out_o <= next_out;
    end
  end

  // expander interrupts, low on the pin means asserted
  assign exp_active = alt_sel[`PIN_EXP0_IRQ +: 3] &
                      ~pin_lvl[`PIN_EXP0_IRQ +: 3];
  assign exp_event = exp_active & ~exp_active_q;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exp_active_q <= 3'h0;
      expander_irq_o <= 3'h0;
    end else begin
      exp_active_q <= exp_active;
      expander_irq_o <= exp_active;
    end
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status <= 3'h0;
    end else if (wr_now && wr_addr == `OFS_CLEAR) begin
      status <= (status & ~hwdata_i[`EVT_W-1:0]) | exp_event;
    end else begin
      status <= status | exp_event;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      enable <= 3'h0;
    end else if (wr_now && wr_addr == `OFS_ENABLE) begin
      enable <= hwdata_i[`EVT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & enable);
    end
  end

  // strap caught once after reset, when the filter has settled
  // later changes on the strap are ignored until the next reset
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_cnt <= 3'h0;
      strap_taken <= 1'b0;
      ref_is_125_o <= 1'b0;
      ref_mhz_o <= `REFCLK_LO_MHZ;
    end else if (!strap_taken) begin
      if (settle_cnt == `STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        ref_is_125_o <= strap_lvl;
        ref_mhz_o <= strap_lvl ? `REFCLK_HI_MHZ : `REFCLK_LO_MHZ;
      end else begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end
endmodule : gpio_alternate_function_mux
`default_nettype wire

// ---- gpio_mux_defs.svh ----
`ifndef GPIO_MUX_DEFS_SVH
`define GPIO_MUX_DEFS_SVH

// pin count and alternate-capable pin masks
`define GPIO_W 11
`define ALT_ANY_MASK 11'h69F
`define ALT_OUT_MASK 11'h683
`define ALT_IN_MASK 11'h01C

// pin positions of the alternate functions
`define PIN_PORT2_RST 0
`define PIN_PORT4_RST 1
`define PIN_EXP0_IRQ 2
`define PIN_GPE 7
`define PIN_PORT3_RST 9
`define PIN_PORT5_RST 10

// register byte offsets
`define OFS_DIR 8'h00
`define OFS_DOUT 8'h04
`define OFS_PIN_IN 8'h08
`define OFS_ALT_SEL 8'h0C
`define OFS_CTRL 8'h10
`define OFS_STATUS 8'h14
`define OFS_CLEAR 8'h18
`define OFS_ENABLE 8'h1C
`define OFS_REFCLK 8'h20

// control register fields
`define CTRL_W 5
`define CTRL_PORT2 0
`define CTRL_PORT3 1
`define CTRL_PORT4 2
`define CTRL_PORT5 3
`define CTRL_GPE 4

// event register width (one bit per expander)
`define EVT_W 3

// reset values
`define DIR_RST 11'h000
`define DOUT_RST 11'h000
`define ALT_SEL_RST 11'h000
`define CTRL_RST 5'h00
`define PIN_IDLE 11'h7FF

// reference clock choices and strap settle time
`define REFCLK_LO_MHZ 8'h64
`define REFCLK_HI_MHZ 8'h7D
`define STRAP_SETTLE 3'h4

`endif

// ---- gpio_mux_pkg.sv ----
package gpio_mux_pkg;
  // alternate-select load from a secondary source
  typedef struct packed {
    logic load;
    logic [10:0] sel;
  } alt_load_t;
endpackage : gpio_mux_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // raw and filtered level
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;

  // three-stage chain; s1 feeds only s2
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once stages two and three agree
  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_o <= INIT;
    end else begin
      q_o <= (agree & s3) | (~agree & q_o);
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- gpio_board.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_board (
  // drive from the block
  input wire logic [10:0] out_i,
  input wire logic [10:0] oe_i,
  // open-drain pull-downs of board parts
  input wire logic [10:0] pull_low_i,
  // resolved pin levels
  output logic [10:0] pin_o
);
  always_comb begin
    pin_o = (oe_i & out_i) | (~oe_i & ~pull_low_i);
  end
endmodule : gpio_board
`default_nettype wire

// ---- gpio_mux_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_mux_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic refclk_freq_select_i,
  input wire logic [10:0] gpio_in_i,
  input wire logic [10:0] gpio_oe_o,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic ref_is_125_o,
  input wire logic [7:0] ref_mhz_o,
  input wire logic [2:0] expander_irq_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ref_mhz: assert property (
    ref_mhz_o == (ref_is_125_o ? 8'h7D : 8'h64))
    else $error("mhz disagrees with strap flag");
  a_strap_src: assert property (
    $changed(ref_is_125_o) |-> ref_is_125_o && refclk_freq_select_i)
    else $error("strap flag moved wrongly");
  a_strap_hold: assert property (
    ref_is_125_o |=> ref_is_125_o)
    else $error("strap flag dropped");
  a_bus_ready: assert property (
    $past(rst_b_i) |-> hreadyout_o)
    else $error("bus stalled");
  a_bus_okay: assert property (
    !hresp_o)
    else $error("bus error answer");
  a_exp_cause: assert property (
    (expander_irq_o & ~$past(expander_irq_o)
      & $past(gpio_in_i[4:2], 4)) == 3'h0)
    else $error("expander flag without low pin");
  a_exp_undriven: assert property (
    (expander_irq_o & $past(expander_irq_o) & gpio_oe_o[4:2]) == 3'h0)
    else $error("expander pin driven");
  a_data_upper: assert property (
    hrdata_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  c_exp: cover property ($rose(expander_irq_o[0]));
  c_irq: cover property ($rose(irq_o));
  c_125: cover property ($rose(ref_is_125_o));
endmodule : gpio_mux_sva
bind gpio_alternate_function_mux gpio_mux_sva u_sva (.ref_clk_i,
  .rst_b_i, .refclk_freq_select_i, .gpio_in_i, .gpio_oe_o, .hrdata_o,
  .hreadyout_o, .hresp_o, .ref_is_125_o, .ref_mhz_o, .expander_irq_o,
  .irq_o);
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gpio_mux_defs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
  import gpio_mux_pkg::*;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, strap = 0, gpe = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [10:0] out, oe, pin, low = 0;
  logic [3:0] preq = 0;
  logic [2:0] xirq;
  logic hrdy, hresp, irq, is125;
  logic [7:0] mhz;
  alt_load_t smb = '0, eep = '0;
  int n_errors = 0, checks = 0;
  int pinmap[5] = '{0, 9, 1, 10, 7}; // control bit to pin
  // clock
  always #2.5 clk = ~clk;
  gpio_alternate_function_mux uut (.ref_clk_i(clk), .rst_b_i(rst_b),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .gpio_in_i(pin), .gpio_out_o(out),
    .gpio_oe_o(oe), .refclk_freq_select_i(strap), .ref_is_125_o(is125),
    .ref_mhz_o(mhz), .smb_alt_i(smb), .eeprom_alt_i(eep),
    .port_reset_req_i(preq), .gpe_req_i(gpe), .expander_irq_o(xirq),
    .irq_o(irq));
  gpio_board board (.out_i(out), .oe_i(oe), .pull_low_i(low), .pin_o(pin));
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one single-word transfer, waits on ready in both phases
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'h1);
    q = hrdata;
  endtask : bus
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    `CHK(n, e, q)
    `CHK("resp", 1'h0, hresp)
  endtask : rchk
  task do_reset(input logic s);
    strap <= s;
    rst_b <= 1'h0;
    cyc(5);
    rst_b <= 1'h1;
    cyc(8);
  endtask : do_reset
  task t_reset;
    `CHK("oe", 11'h000, oe)
    `CHK("is125", 1'h0, is125)
    `CHK("mhz", 8'h64, mhz)
    rchk("alt", `OFS_ALT_SEL, 32'h0);
    rchk("ref", `OFS_REFCLK, 32'h6400);
    rchk("none", 8'h40, 32'h0);
  endtask : t_reset
  task t_gpio;
    bus(`OFS_DOUT, 1'h1, 32'h555);
    bus(`OFS_DIR, 1'h1, 32'h0F0);
    cyc(6);
    `CHK("oe", 11'h0F0, oe)
    `CHK("out", 11'h555, out)
    rchk("pin", `OFS_PIN_IN, 32'h75F);
    bus(`OFS_DIR, 1'h1, 32'h0);
    bus(`OFS_DOUT, 1'h1, 32'h0);
  endtask : t_gpio
  // each control bit, then each request, low on its own pin only
  task t_alt_out;
    int i;
    bus(`OFS_ALT_SEL, 1'h1, 32'h7FF);
    rchk("alt", `OFS_ALT_SEL, 32'h69F);
    for (i = 0; i < 5; i++) begin
      bus(`OFS_CTRL, 1'h1, 32'h1 << i);
      cyc(2);
      `CHK("ctl", 11'h69F & ~(11'h1 << pinmap[i]), out)
      `CHK("oe", 11'h683, oe)
      bus(`OFS_CTRL, 1'h1, 32'h0);
      preq <= 4'h1 << i;
      gpe <= (i == 4);
      cyc(3);
      `CHK("req", 11'h69F & ~(11'h1 << pinmap[i]), out)
      preq <= 4'h0;
      gpe <= 1'h0;
    end
  endtask : t_alt_out
  task t_irq;
    bus(`OFS_ENABLE, 1'h1, 32'h1);
    low <= 11'h004;
    cyc(8);
    `CHK("xirq", 3'h1, xirq)
    `CHK("irq", 1'h1, irq)
    low <= 11'h008;
    cyc(8);
    `CHK("xirq", 3'h2, xirq)
    rchk("sts", `OFS_STATUS, 32'h3);
    bus(`OFS_CLEAR, 1'h1, 32'h1);
    cyc(3);
    `CHK("irq", 1'h0, irq)
    bus(`OFS_CLEAR, 1'h1, 32'h2);
    low <= 11'h000;
    rchk("sts", `OFS_STATUS, 32'h0);
  endtask : t_irq
  // serial management wins over eeprom in the same cycle
  task t_load;
    smb <= {1'h1, 11'h7FE};
    eep <= {1'h1, 11'h002};
    cyc(1);
    smb <= '0;
    eep <= '0;
    rchk("smb", `OFS_ALT_SEL, 32'h69E);
    eep <= {1'h1, 11'h004};
    cyc(1);
    eep <= '0;
    rchk("eep", `OFS_ALT_SEL, 32'h4);
  endtask : t_load
  // a second reset with the strap high picks the faster reference
  task t_strap;
    do_reset(1'h1);
    `CHK("is125", 1'h1, is125)
    `CHK("mhz", 8'h7D, mhz)
    rchk("ref", `OFS_REFCLK, 32'h7D01);
  endtask : t_strap
  task print_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    do_reset(1'h0);
    t_reset;
    t_gpio;
    t_alt_out;
    t_irq;
    t_load;
    t_strap;
    print_verdict;
  end
  // watchdog, far beyond the roughly 134 cycles needed
  initial begin
    cyc(5000);
    n_errors++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
